// [core/dummy_unused_placeholder_none.v]
// (intentionally no content beyond this line)

// [core/quad_wiper_consts.vh]
// Constants for the quad wiper serial register block
`ifndef QUAD_WIPER_CONSTS_VH
`define QUAD_WIPER_CONSTS_VH

// Geometry
`define WIPER_COUNT 4
`define SETTINGS_PER_WIPER 4
`define POS_WIDTH 6
`define TAP_COUNT 64
`define POS_MAX 6'h3F
`define POS_MIN 6'h00
`define SETTING_RESET 6'h00

// First byte fields
`define ID_TYPE_HI 7
`define ID_TYPE_LO 4
`define ID_TYPE_DEFAULT 4'hA
`define ID_ZERO_FIELD 2'h0

// Instruction byte fields
`define OP_HI 7
`define OP_LO 4
`define REG_HI 3
`define REG_LO 2
`define WIPER_HI 1
`define WIPER_LO 0

// Instruction codes
`define OP_READ_POS 4'h9
`define OP_WRITE_POS 4'hA
`define OP_READ_SETTING 4'hB
`define OP_WRITE_SETTING 4'hC
`define OP_XFR_SET_TO_POS 4'hD
`define OP_XFR_POS_TO_SET 4'hE
`define OP_GXFR_SET_TO_POS 4'h1
`define OP_GXFR_POS_TO_SET 4'h8
`define OP_INC_DEC 4'h2
`define OP_READ_STATUS 4'h5

// Nonvolatile write time
`define CLOCK_KHZ 25000
`define NV_WRITE_MS 10
`define NV_WRITE_CYCLES (`NV_WRITE_MS * `CLOCK_KHZ)
`define NV_COUNT_WIDTH 18

`endif

// [core/quad_wiper_register_serial_ctrl.v]
// Serial command logic, position and setting registers for four wipers
`include "quad_wiper_consts.vh"

module quad_wiper_register_serial_ctrl #(
    parameter [3:0] DEVICE_TYPE = `ID_TYPE_DEFAULT, // Arbitrary type code
    parameter NV_WRITE_CYCLES = `NV_WRITE_CYCLES
) (
    input wire clock,
    input wire srst,
    input wire clkEn,
    input wire chipSelectN,
    input wire serialClock,
    input wire serialIn,
    input wire pauseN,
    input wire writeProtectN,
    input wire [1:0] bus_select_pins,
    output wire serialOut,
    output wire serialOutEn,
    output wire nv_write_pending,
    output wire [`TAP_COUNT-1:0] tapSelect0,
    output wire [`TAP_COUNT-1:0] tapSelect1,
    output wire [`TAP_COUNT-1:0] tapSelect2,
    output wire [`TAP_COUNT-1:0] tapSelect3
);
    // Serial sequence states
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ID = 3'h1;
    localparam [2:0] ST_INSTR = 3'h2;
    localparam [2:0] ST_DATA = 3'h3;
    localparam [2:0] ST_READ = 3'h4;
    localparam [2:0] ST_INCDEC = 3'h5;
    localparam [2:0] ST_SKIP = 3'h6;

    // Pin synchronisers: two stages, then an edge history flop
    reg [6:0] pinMeta;
    reg [6:0] pinSync;
    reg csPrev;
    reg sckPrev;

    wire csS = pinSync[0];
    wire sckS = pinSync[1];
    wire siS = pinSync[2];
    wire holdS = pinSync[3];
    wire wpS = pinSync[4];
    wire [1:0] busS = pinSync[6:5];

    wire csFall = csPrev & ~csS;
    wire csRise = ~csPrev & csS;
    wire sckRise = ~sckPrev & sckS;
    wire sckFall = sckPrev & ~sckS;

    // Sequence state
    reg [2:0] state;
    reg [2:0] bitCount;
    reg [6:0] shiftIn;
    reg [7:0] shiftOut;
    reg [3:0] cmdOp;
    reg [1:0] cmdReg;
    reg [1:0] cmdWiper;
    reg soData;
    reg soEnable;

    // Volatile positions and stored settings
    reg [`POS_WIDTH-1:0] wiper_position_reg [0:`WIPER_COUNT-1];
    reg [`POS_WIDTH-1:0] storedSetting [0:`WIPER_COUNT*`SETTINGS_PER_WIPER-1];
    reg recallPending;

    // Queued stored write, committed after the write time
    reg writeReady;
    reg [3:0] pendMask;
    reg [1:0] pendReg;
    reg [`WIPER_COUNT*`POS_WIDTH-1:0] pendData;
    reg nvBusy;
    reg [`NV_COUNT_WIDTH-1:0] nvCount;

    // Byte completed by the current rising edge
    wire [7:0] byteIn = {shiftIn, siS};
    wire byteDone = sckRise && (bitCount == 3'h7);
    wire [3:0] inOp = byteIn[`OP_HI:`OP_LO];
    wire [1:0] inReg = byteIn[`REG_HI:`REG_LO];
    wire [1:0] inWiper = byteIn[`WIPER_HI:`WIPER_LO];
    wire [`POS_WIDTH-1:0] curPos = wiper_position_reg[cmdWiper];

    integer i;
    integer j;

    assign serialOut = soData;
    assign serialOutEn = soEnable;
    assign nv_write_pending = nvBusy;

    // Two flops before any logic reads the pins
    always @(posedge clock) begin
        if (srst) begin
            pinMeta <= 7'h19;
            pinSync <= 7'h19;
            csPrev <= 1'b1;
            sckPrev <= 1'b0;
        end else if (clkEn) begin
            pinMeta <= {bus_select_pins, writeProtectN, pauseN, serialIn,
                        serialClock, chipSelectN};
            pinSync <= pinMeta;
            csPrev <= pinSync[0];
            sckPrev <= pinSync[1];
        end
    end

    // Nonvolatile write timer and commit
    always @(posedge clock) begin
        if (srst) begin
            nvBusy <= 1'b0;
            nvCount <= {`NV_COUNT_WIDTH{1'b0}};
        end else if (clkEn) begin
            if (nvBusy) begin
                if (nvCount == NV_WRITE_CYCLES - 1) begin
                    nvBusy <= 1'b0;
                end
                nvCount <= nvCount + 1'b1;
            end else if (csRise && writeReady && wpS) begin
                nvBusy <= 1'b1;
                nvCount <= {`NV_COUNT_WIDTH{1'b0}};
            end
        end
    end

    // Stored settings: reset to blank, written when the timer ends
    always @(posedge clock) begin
        if (srst) begin
            for (j = 0; j < `WIPER_COUNT*`SETTINGS_PER_WIPER; j = j + 1) begin
                storedSetting[j] <= `SETTING_RESET;
            end
        end else if (clkEn) begin
            if (nvBusy && nvCount == NV_WRITE_CYCLES - 1) begin
                for (j = 0; j < `WIPER_COUNT; j = j + 1) begin
                    if (pendMask[j]) begin
                        storedSetting[{j[1:0], pendReg}] <= pendData[j*6 +: 6];
                    end
                end
            end
        end
    end

    // Serial sequence, positions and queued writes
    always @(posedge clock) begin
        if (srst) begin
            state <= ST_IDLE;
            bitCount <= 3'h0;
            shiftIn <= 7'h00;
            shiftOut <= 8'h00;
            cmdOp <= 4'h0;
            cmdReg <= 2'h0;
            cmdWiper <= 2'h0;
            soData <= 1'b0;
            soEnable <= 1'b0;
            writeReady <= 1'b0;
            pendMask <= 4'h0;
            pendReg <= 2'h0;
            pendData <= 24'h000000;
            recallPending <= 1'b1;
            for (i = 0; i < `WIPER_COUNT; i = i + 1) begin
                wiper_position_reg[i] <= `POS_MIN;
            end
        end else if (clkEn) begin
            // Power-up recall from the first stored setting
            if (recallPending) begin
                recallPending <= 1'b0;
                for (i = 0; i < `WIPER_COUNT; i = i + 1) begin
                    wiper_position_reg[i] <= storedSetting[{i[1:0], 2'h0}];
                end
            end

            if (csS) begin
                // Deselected: release output, drop partial commands
                state <= ST_IDLE;
                soEnable <= 1'b0;
                writeReady <= 1'b0;
            end else if (csFall) begin
                state <= ST_ID;
                bitCount <= 3'h0;
                writeReady <= 1'b0;
            end else if (holdS) begin
                // Input capture on rising serial clock
                if (sckRise) begin
                    shiftIn <= byteIn[6:0];
                    bitCount <= bitCount + 1'b1;
                end

                if (byteDone && state == ST_ID) begin
                    if (byteIn[1:0] == busS && byteIn[3:2] == `ID_ZERO_FIELD &&
                        byteIn[`ID_TYPE_HI:`ID_TYPE_LO] == DEVICE_TYPE) begin
                        state <= ST_INSTR;
                    end else begin
                        state <= ST_SKIP;
                    end
                end else if (byteDone && state == ST_INSTR) begin
                    cmdOp <= inOp;
                    cmdReg <= inReg;
                    cmdWiper <= inWiper;
                    state <= ST_SKIP;
                    if (nvBusy && inOp != `OP_READ_STATUS) begin
                        state <= ST_SKIP;
                    end else if (inOp == `OP_READ_POS) begin
                        shiftOut <= {2'h0, wiper_position_reg[inWiper]};
                        state <= ST_READ;
                    end else if (inOp == `OP_READ_SETTING) begin
                        shiftOut <= {2'h0, storedSetting[{inWiper, inReg}]};
                        state <= ST_READ;
                    end else if (inOp == `OP_READ_STATUS) begin
                        shiftOut <= {7'h00, nvBusy};
                        state <= ST_READ;
                    end else if (inOp == `OP_WRITE_POS || inOp == `OP_WRITE_SETTING) begin
                        state <= ST_DATA;
                    end else if (inOp == `OP_XFR_SET_TO_POS) begin
                        wiper_position_reg[inWiper] <= storedSetting[{inWiper, inReg}];
                    end else if (inOp == `OP_GXFR_SET_TO_POS) begin
                        for (i = 0; i < `WIPER_COUNT; i = i + 1) begin
                            wiper_position_reg[i] <= storedSetting[{i[1:0], inReg}];
                        end
                    end else if (inOp == `OP_XFR_POS_TO_SET) begin
                        pendMask <= 4'h1 << inWiper;
                        pendReg <= inReg;
                        for (i = 0; i < `WIPER_COUNT; i = i + 1) begin
                            pendData[i*6 +: 6] <= wiper_position_reg[i];
                        end
                        writeReady <= 1'b1;
                    end else if (inOp == `OP_GXFR_POS_TO_SET) begin
                        pendMask <= 4'hF;
                        pendReg <= inReg;
                        for (i = 0; i < `WIPER_COUNT; i = i + 1) begin
                            pendData[i*6 +: 6] <= wiper_position_reg[i];
                        end
                        writeReady <= 1'b1;
                    end else if (inOp == `OP_INC_DEC) begin
                        state <= ST_INCDEC;
                    end
                end else if (byteDone && state == ST_DATA) begin
                    state <= ST_SKIP;
                    if (cmdOp == `OP_WRITE_POS) begin
                        wiper_position_reg[cmdWiper] <= byteIn[5:0];
                    end else begin
                        pendMask <= 4'h1 << cmdWiper;
                        pendReg <= cmdReg;
                        for (i = 0; i < `WIPER_COUNT; i = i + 1) begin
                            pendData[i*6 +: 6] <= byteIn[5:0];
                        end
                        writeReady <= 1'b1;
                    end
                end else if (sckRise && state == ST_INCDEC) begin
                    // One step per rising serial clock, clamped at the ends
                    if (siS && curPos != `POS_MAX) begin
                        wiper_position_reg[cmdWiper] <= curPos + 1'b1;
                    end else if (!siS && curPos != `POS_MIN) begin
                        wiper_position_reg[cmdWiper] <= curPos - 1'b1;
                    end
                end

                // Read data leaves on falling serial clock, MSB first
                if (sckFall && state == ST_READ) begin
                    soData <= shiftOut[7];
                    shiftOut <= {shiftOut[6:0], 1'b0};
                    soEnable <= 1'b1;
                end
            end
        end
    end

    // One registered tap decoder per wiper
    wire [`WIPER_COUNT*`TAP_COUNT-1:0] tapAll;
    genvar g;
    generate
        for (g = 0; g < `WIPER_COUNT; g = g + 1) begin : decode
            tap_decoder #(
                .POS_WIDTH(`POS_WIDTH),
                .TAPS(`TAP_COUNT)
            ) u_dec (
                .clock(clock),
                .srst(srst),
                .clkEn(clkEn),
                .position(wiper_position_reg[g]),
                .taps(tapAll[g*`TAP_COUNT +: `TAP_COUNT])
            );
        end
    endgenerate

    // Tap enables straight from decoder flops
    assign tapSelect0 = tapAll[0*`TAP_COUNT +: `TAP_COUNT];
    assign tapSelect1 = tapAll[1*`TAP_COUNT +: `TAP_COUNT];
    assign tapSelect2 = tapAll[2*`TAP_COUNT +: `TAP_COUNT];
    assign tapSelect3 = tapAll[3*`TAP_COUNT +: `TAP_COUNT];
endmodule

// [core/tap_decoder.v]
// Registered one-hot decoder from wiper position to tap switch enables
`include "quad_wiper_consts.vh"

module tap_decoder #(
    parameter POS_WIDTH = `POS_WIDTH,
    parameter TAPS = `TAP_COUNT
) (
    input wire clock,
    input wire srst,
    input wire clkEn,
    input wire [POS_WIDTH-1:0] position,
    output reg [TAPS-1:0] taps
);
    integer k;

    // Exactly one enable follows the position
    always @(posedge clock) begin
        if (srst) begin
            taps <= {{(TAPS-1){1'b0}}, 1'b1};
        end else if (clkEn) begin
            for (k = 0; k < TAPS; k = k + 1) begin
                taps[k] <= (position == k[POS_WIDTH-1:0]);
            end
        end
    end
endmodule

// [verif/quad_wiper_register_serial_ctrl_tb_top.sv]
// Self-checking bench for the quad wiper serial register block
module quad_wiper_register_serial_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NvCycles = 400;
    typedef struct {logic [31:0] bits; int n; logic chk; logic [7:0] exp;} row_t;
    logic clock, srst, clkEn, pauseN, writeProtectN;
    logic [1:0] busPins;
    logic [7:0] rd;
    wire logic chipSelectN, serialClock, serialIn, serialOut, serialOutEn, pending, soLine;
    wire logic [63:0] taps0, taps1, taps2, taps3;
    int err_total, total_checks, cycles;
    row_t rows[22];

    quad_wiper_register_serial_ctrl #(.NV_WRITE_CYCLES(NvCycles)) DUT (
        .clock(clock), .srst(srst), .clkEn(clkEn), .chipSelectN(chipSelectN),
        .serialClock(serialClock), .serialIn(serialIn), .pauseN(pauseN),
        .writeProtectN(writeProtectN), .bus_select_pins(busPins), .serialOut(serialOut),
        .serialOutEn(serialOutEn), .nv_write_pending(pending), .tapSelect0(taps0),
        .tapSelect1(taps1), .tapSelect2(taps2), .tapSelect3(taps3));
    serial_host host (.clock(clock), .chipSelectN(chipSelectN), .serialClock(serialClock),
        .serialIn(serialIn), .serialOut(soLine));
    // Released output reads inverted, so a read without enable fails
    assign soLine = serialOutEn ? serialOut : ~serialOut;

    // Clock source
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check64(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits out any stored write, bounded
    task automatic wait_idle;
        for (int i = 0; i < 600 && pending !== 1'b0; i++) @(posedge clock);
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        srst = 1'b1;
        clkEn = 1'b1;
        pauseN = 1'b1;
        writeProtectN = 1'b1;
        busPins = 2'h2;
        rows = '{
            '{32'hA2A12A, 24, 1'b0, 8'h00}, '{32'hA29100, 24, 1'b1, 8'h2A},
            '{32'hA2CB15, 24, 1'b0, 8'h00}, '{32'hA2BB00, 24, 1'b1, 8'h15},
            '{32'hA2DB, 16, 1'b0, 8'h00}, '{32'hA29300, 24, 1'b1, 8'h15},
            '{32'hA2E5, 16, 1'b0, 8'h00}, '{32'hA2B500, 24, 1'b1, 8'h2A},
            '{32'hA214, 16, 1'b0, 8'h00}, '{32'hA29300, 24, 1'b1, 8'h00},
            '{32'hA28C, 16, 1'b0, 8'h00}, '{32'hA2BD00, 24, 1'b1, 8'h2A},
            '{32'hA1A23F, 24, 1'b0, 8'h00}, '{32'hA29200, 24, 1'b1, 8'h00},
            '{32'hA2207, 20, 1'b0, 8'h00}, '{32'hA29000, 24, 1'b1, 8'h03},
            '{32'hA2A23F, 24, 1'b0, 8'h00}, '{32'hA222F, 20, 1'b0, 8'h00},
            '{32'hA29200, 24, 1'b1, 8'h3F}, '{32'hA2C03, 20, 1'b0, 8'h00},
            '{32'hA2B000, 24, 1'b1, 8'h00}, '{32'hA25000, 24, 1'b1, 8'h00}};
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        foreach (rows[i]) begin
            host.frame(rows[i].bits, rows[i].n, rd);
            wait_idle();
            if (rows[i].chk) check8(rd, rows[i].exp);
        end
        // Positions decoded onto each wiper's own taps
        check64(taps0, 64'h1 << 6'h03);
        check64(taps1, 64'h1 << 6'h2A);
        check64(taps2, 64'h1 << 6'h3F);
        check64(taps3, 64'h1);
        // Status read while a stored write is under way, then commit
        host.frame(32'hA2CD15, 24, rd);
        host.frame(32'hA25000, 24, rd);
        check8(rd, 8'h01);
        check8({7'h00, pending}, 8'h01);
        wait_idle();
        host.frame(32'hA2BD00, 24, rd);
        check8(rd, 8'h15);
        // Pause low, then a frozen clock, each hide a whole position write
        pauseN <= 1'b0;
        host.frame(32'hA2A011, 24, rd);
        pauseN <= 1'b1;
        clkEn <= 1'b0;
        host.frame(32'hA2A011, 24, rd);
        clkEn <= 1'b1;
        host.frame(32'hA29000, 24, rd);
        check8(rd, 8'h03);
        // Protect low at select release drops the queued stored write
        writeProtectN <= 1'b0;
        host.frame(32'hA2C02B, 24, rd);
        writeProtectN <= 1'b1;
        check8({7'h00, pending}, 8'h00);
        host.frame(32'hA2B000, 24, rd);
        check8(rd, 8'h00);
        // Second reset restores the power-up position
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        check64(taps2, 64'h1);
        host.frame(32'hA29200, 24, rd);
        check8(rd, 8'h00);
        report_and_stop();
    end
endmodule

// [verif/quad_wiper_sva.sv]
// Concurrent checks on the quad wiper serial block's ports
module quad_wiper_sva #(
    parameter NV_WRITE_CYCLES = 250000
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic chipSelectN,
    input wire logic serialOutEn,
    input wire logic nv_write_pending,
    input wire logic [63:0] tapSelect0,
    input wire logic [63:0] tapSelect1,
    input wire logic [63:0] tapSelect2,
    input wire logic [63:0] tapSelect3
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    int pendCount;
    // Length of the current stored write in cycles
    always_ff @(posedge clock) begin
        if (srst || !nv_write_pending) begin
            pendCount <= 0;
        end else begin
            pendCount <= pendCount + 1;
        end
    end
    taps_onehot_a: assert property ($onehot(tapSelect0) && $onehot(tapSelect1)
        && $onehot(tapSelect2) && $onehot(tapSelect3)) else $error("tap enables not one-hot");
    reset_state_a: assert property (disable iff (!clkEn) srst |=> tapSelect2 == 64'h1
        && !nv_write_pending && !serialOutEn) else $error("reset state wrong");
    out_release_a: assert property (chipSelectN [*7] |-> !serialOutEn)
        else $error("serial output driven while deselected");
    out_start_a: assert property ($rose(serialOutEn) |-> !chipSelectN)
        else $error("serial output enabled outside a frame");
    commit_on_release_a: assert property ($rose(nv_write_pending) |->
        chipSelectN && $past(chipSelectN, 2)) else $error("stored write began in a frame");
    write_time_a: assert property (pendCount <= NV_WRITE_CYCLES)
        else $error("stored write too long");
    pending_hold_a: assert property ($rose(nv_write_pending) |=>
        nv_write_pending [*4]) else $error("pending flag dropped early");
    taps_idle_a: assert property (chipSelectN [*8] |-> $stable(tapSelect0)
        && $stable(tapSelect1) && $stable(tapSelect2) && $stable(tapSelect3))
        else $error("taps moved while idle");
endmodule

bind quad_wiper_register_serial_ctrl quad_wiper_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (
    .clock(clock), .srst(srst), .clkEn(clkEn), .chipSelectN(chipSelectN),
    .serialOutEn(serialOutEn), .nv_write_pending(nv_write_pending), .tapSelect0(tapSelect0),
    .tapSelect1(tapSelect1), .tapSelect2(tapSelect2), .tapSelect3(tapSelect3));

// [verif/serial_host.sv]
// Host serial master model driving select, serial clock and data
module serial_host (
    input wire logic clock,
    output logic chipSelectN,
    output logic serialClock,
    output logic serialIn,
    input wire logic serialOut
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle: deselected, serial clock parked low
    initial begin
        chipSelectN = 1'b1;
        serialClock = 1'b0;
        serialIn = 1'b0;
    end
    // Sends n bits MSB first, collecting read bits just before each fall
    task automatic frame(input logic [31:0] bits, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clock) chipSelectN <= 1'b0;
        repeat (4) @(posedge clock);
        for (int i = n - 1; i >= 0; i--) begin
            serialIn <= bits[i];
            repeat (4) @(posedge clock);
            serialClock <= 1'b1;
            repeat (4) @(posedge clock);
            rd = {rd[6:0], serialOut};
            serialClock <= 1'b0;
        end
        repeat (4) @(posedge clock);
        chipSelectN <= 1'b1;
        serialIn <= ~serialIn;
        repeat (12) @(posedge clock);
    endtask
endmodule
